// File: mpc_far_end.sv
// Far-end modem model: makes both serial clocks, sends receive bits, decodes sent characters.
// Assumes the controller samples its receive line on rising receive clock edges.
`timescale 1ns/1ps
`default_nettype none
module mpc_far_end
(
	// Link pins
	output var logic       tx_bit_clock,
	output var logic       rx_bit_clock,
	output var logic       serial_rx_in,
	input wire logic       serial_tx_out,
	// Decoded characters
	output var logic [7:0] got_byte,
	output var logic       got_t
);
	int cnt;
	logic [7:0] sh;
	// Transmit clock runs free; the offset keeps its edges off ref_clk edges
	initial
	begin
		rx_bit_clock = 1'b0;
		serial_rx_in = 1'b1;
		tx_bit_clock = 1'b0;
		#13;
		forever #40 tx_bit_clock = ~tx_bit_clock;
	end
	// Sample half a bit after the line moved: start, eight data bits, stop
	always @(negedge tx_bit_clock)
	begin
		if (cnt == 0)
			cnt <= (serial_tx_out === 1'b0);
		else if (cnt < 9)
		begin
			sh <= {serial_tx_out, sh[7:1]};
			cnt <= cnt + 1;
		end
		else
		begin
			cnt <= 0;
			got_byte <= sh;
			got_t <= !got_t;
		end
	end
	// Receive clock only runs within a frame; data moves on its falling edge
	task send_bits(input logic [23:0] v, input int n, input int rep);
		int i;
		int k;
		begin
			#3;
			for (i = 0; i < n; i++)
			begin
				serial_rx_in = v[i];
				for (k = 0; k < rep; k++)
				begin
					#40 rx_bit_clock = 1'b1;
					#40 rx_bit_clock = 1'b0;
				end
			end
			serial_rx_in = 1'b1;
		end
	endtask
	initial
	begin
		cnt = 0;
		got_t = 1'b0;
	end
endmodule // mpc_far_end
`default_nettype wire

// File: mpc_serial_ctrl.v
// Multiprotocol serial controller: APB register slave, transmitter, receiver, modem pins.
// Assumes one 100 MHz ref_clk; serial clocks, serial data and modem pins are asynchronous.
//
// Behaviour
// - Transmit line changes only at a rising transmit clock edge.
// - Request-to-send low when its control bit is set; transmit needs it plus clear-to-send.
// - Clear-to-send, data-set-ready and carrier-detect readable in transmitter status.
// - Data-terminal-ready low from control bit; general pin drivable low and readable.
// - Char-available rises on a complete char, falls when that buffer read ends.
// - Buffer-empty high when free; cleared at first transmit clock after a write.
// - Sync-or-flag output pulses high for exactly one receive clock period.
// - Byte input high selects 8-bit bus with lanes joined; low selects 16-bit.
// - Three-bit register index selects registers, each reachable as 8 or 16 bits.
// - Read drives the addressed register onto the bus; write loads it.
// - Interrupt low on overrun, end-of-message or underrun; released by status read.
// - Initialise input low resets control registers and timing.
// - Asynchronous clock factor of 1, 8, 16 or 32 selectable.
// - Inverted coding: line toggles for zero, holds for one.
// - Underrun sends abort in bit-oriented mode, fill characters in byte-control mode.
// - Overrun set when a new char arrives before the previous one was read.
// - Start-of-message bit starts syncs or flags and clears itself.
// - Bit-oriented mode sets end-of-message on flag, abort or go-ahead.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_serial_ctrl_regs.vh"

module mpc_serial_ctrl
(
	// Clock and reset
	input  wire        ref_clk,
	input  wire        reset,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Bus width and initialise pins
	input  wire        byte_mode,
	input  wire        init_n,
	// Serial link
	input  wire        tx_bit_clock,
	input  wire        rx_bit_clock,
	output wire        serial_tx_out,
	input  wire        serial_rx_in,
	// Modem pins
	output wire        rts_n,
	input  wire        cts_n,
	output wire        dtr_n,
	input  wire        dsr_n,
	input  wire        cd_n,
	input  wire        misc_in,
	output wire        misc_out,
	output wire        misc_oe_n,
	// Status pins
	output wire        rx_char_available,
	output wire        tx_buffer_empty,
	output wire        rx_sync_flag,
	output wire        irq_n
);

	localparam TX_IDLE = 2'b01;
	localparam TX_SEND = 2'b10;

	// Edges per bit minus one; synchronous protocols always run at 1x
	function [5:0] fac_max;
		input [1:0] code;
		input       async;
		begin
			case (code)
				2'h0:    fac_max = `MPC_FAC_1X;
				2'h1:    fac_max = `MPC_FAC_8X;
				2'h2:    fac_max = `MPC_FAC_16X;
				default: fac_max = `MPC_FAC_32X;
			endcase
			if (!async)
				fac_max = `MPC_FAC_1X;
		end
	endfunction

	// Two-stage synchronisers for every pin from outside the clock domain
	reg  [8:0] meta_q;
	reg  [8:0] sync_q;
	wire [8:0] pins_in = {byte_mode, init_n, tx_bit_clock, rx_bit_clock, serial_rx_in,
		cts_n, dsr_n, cd_n, misc_in};
	always @(posedge ref_clk)
	begin
		meta_q <= pins_in;
		sync_q <= meta_q;
	end
	wire s_byte = sync_q[8];
	wire s_init = sync_q[7];
	wire s_rxd  = sync_q[4];
	wire s_cts  = ~sync_q[3];
	wire s_dsr  = ~sync_q[2];
	wire s_cd   = ~sync_q[1];
	wire s_misc = ~sync_q[0];

	// Edge finders on the synchronised serial clocks
	reg txc_d_q;
	reg rxc_d_q;
	always @(posedge ref_clk)
	begin
		txc_d_q <= sync_q[6];
		rxc_d_q <= sync_q[5];
	end
	wire tx_rise = sync_q[6] & ~txc_d_q;
	wire rx_rise = sync_q[5] & ~rxc_d_q;

	// Control reset: system reset or the initialise pin held low
	wire ctl_rst = reset | ~s_init;

	// Bus decode; a transfer takes effect at the access edge, always with no wait
	wire       acc   = psel & penable;
	wire [2:0] idx   = paddr[4:2];
	wire       unmap = (idx > `MPC_IDX_MODE);
	wire       wr_lo = ~s_byte | ~paddr[`MPC_ADDR_HI_BIT];
	wire       wr_hi = ~s_byte | paddr[`MPC_ADDR_HI_BIT];
	wire [7:0] wd_hi = s_byte ? pwdata[7:0] : pwdata[15:8];
	wire       wr    = acc & pwrite & ~unmap;
	wire       rd    = acc & ~pwrite & ~unmap;
	assign pready  = 1'b1;
	assign pslverr = acc & unmap;

	// Control registers
	reg [15:0] mode_q;
	reg        dtr_q;
	reg        misc_q;
	reg        re_q;
	reg        rts_q;
	reg        som_q;
	reg        eom_q;
	wire [1:0] proto  = mode_q[`MPC_M_PROTO_LO +: 2];
	wire       async  = (proto == `MPC_PROTO_ASYNC);
	wire       bit_oriented_protocol_mode    = (proto == `MPC_PROTO_BOP);
	wire       nrzi   = mode_q[`MPC_M_NRZI];
	wire [7:0] synch  = mode_q[`MPC_M_SYNC_LO +: 8];
	wire [7:0] idle_c = bit_oriented_protocol_mode ? `MPC_FLAG_CHAR : synch;
	wire       tx_en  = rts_q & s_cts;
	wire       wr_tx  = wr & (idx == `MPC_IDX_TX_CTRL);
	wire       tx_dwr = wr_tx & wr_lo;

	// Transmit character selection for the next frame slot
	reg        nxt_go;
	reg [9:0]  nxt_w;
	reg [3:0]  nxt_rem;
	reg        nxt_dat;
	reg        nxt_som;
	reg        nxt_ur;
	reg [7:0]  tx_buf_q;
	reg        tx_full_q;
	reg        started_q;
	reg        msg_q;
	always @*
	begin
		nxt_go  = 1'b0;
		nxt_w   = `MPC_MARK_WORD;
		nxt_rem = 4'h7;
		nxt_dat = 1'b0;
		nxt_som = 1'b0;
		nxt_ur  = 1'b0;
		if (!tx_en)
			nxt_go = 1'b0;
		else if (async)
		begin
			if (tx_full_q)
			begin
				nxt_go  = 1'b1;
				nxt_w   = {1'b1, tx_buf_q, 1'b0};
				nxt_rem = 4'h9;
				nxt_dat = 1'b1;
			end
		end
		else if (som_q)
		begin
			nxt_go  = 1'b1;
			nxt_w   = {2'b11, idle_c};
			nxt_som = 1'b1;
		end
		else if (started_q & tx_full_q)
		begin
			nxt_go  = 1'b1;
			nxt_w   = {2'b11, tx_buf_q};
			nxt_dat = 1'b1;
		end
		else if (started_q)
		begin
			// Idle fill between frames; an open message starved of data is an underrun
			nxt_go = 1'b1;
			nxt_ur = msg_q;
			nxt_w  = {2'b11, (bit_oriented_protocol_mode & msg_q) ? `MPC_ABORT_CHAR : idle_c};
		end
	end

	// Transmitter timing: bit ticks come only from transmit clock rising edges
	reg [1:0] tx_st_q;
	reg [5:0] tx_div_q;
	reg [9:0] tx_sh_q;
	reg [3:0] tx_cnt_q;
	reg       line_q;
	reg       tbe_q;
	reg       wr_pend_q;
	reg       tor_q;
	reg       tur_q;
	wire [5:0] tx_fm   = fac_max(mode_q[`MPC_M_FAC_LO +: 2], async);
	wire       tx_tick = tx_rise & (tx_div_q == tx_fm);
	wire       tx_load = tx_tick & (tx_cnt_q == 4'h0) & nxt_go;
	wire       tx_bit  = (tx_cnt_q != 4'h0) ? tx_sh_q[0] : (tx_load ? nxt_w[0] : 1'b1);
	wire       clr_tx  = rd & (idx == `MPC_IDX_RX_CTRL);

	always @(posedge ref_clk)
	begin
		if (ctl_rst)
		begin
			tx_st_q   <= TX_IDLE;
			tx_div_q  <= 6'h00;
			tx_sh_q   <= `MPC_MARK_WORD;
			tx_cnt_q  <= 4'h0;
			line_q    <= 1'b1;
			started_q <= 1'b0;
			msg_q     <= 1'b0;
		end
		else
		begin
			if (tx_rise)
				tx_div_q <= (tx_div_q == tx_fm) ? 6'h00 : tx_div_q + 6'h01;
			if (!tx_en)
				started_q <= 1'b0;
			if (tx_tick)
			begin
				// Inverted coding toggles the line for a zero and holds it for a one
				line_q <= nrzi ? (tx_bit ? line_q : ~line_q) : tx_bit;
				case (tx_st_q)
					TX_IDLE:
					begin
						if (tx_load)
						begin
							tx_sh_q  <= {1'b1, nxt_w[9:1]};
							tx_cnt_q <= nxt_rem;
							tx_st_q  <= TX_SEND;
						end
					end
					TX_SEND:
					begin
						tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
						tx_cnt_q <= tx_cnt_q - 4'h1;
						if (tx_cnt_q == 4'h1)
							tx_st_q <= TX_IDLE;
					end
					default: tx_st_q <= TX_IDLE;
				endcase
				if (tx_load & nxt_som)
					started_q <= 1'b1;
				if (tx_load & nxt_dat & ~async)
					msg_q <= ~eom_q;
				if (tx_load & nxt_ur & bit_oriented_protocol_mode)
					msg_q <= 1'b0;
			end
		end
	end
	assign serial_tx_out = line_q;

	// Transmit buffer, buffer-empty pin and transmitter flags
	always @(posedge ref_clk)
	begin
		if (ctl_rst)
		begin
			tx_buf_q  <= 8'h00;
			tx_full_q <= 1'b0;
			tbe_q     <= 1'b1;
			wr_pend_q <= 1'b0;
			tor_q     <= 1'b0;
			tur_q     <= 1'b0;
		end
		else
		begin
			// Empty drops at the first clock after a write even when that clock moves
			// the word on; it comes back at a later clock once the buffer is free
			if (tx_load & nxt_dat)
				tx_full_q <= 1'b0;
			if (tx_rise & wr_pend_q)
			begin
				tbe_q     <= 1'b0;
				wr_pend_q <= 1'b0;
			end
			else if (tx_rise & ~tx_full_q)
				tbe_q <= 1'b1;
			if (tx_dwr)
			begin
				tx_buf_q  <= pwdata[7:0];
				tx_full_q <= 1'b1;
				wr_pend_q <= 1'b1;
			end
			// Status reads clear the flags, but a new event in the same cycle wins
			if (clr_tx)
			begin
				tor_q <= 1'b0;
				tur_q <= 1'b0;
			end
			if (tx_dwr & tx_full_q & ~(tx_load & nxt_dat))
				tor_q <= 1'b1;
			if (tx_load & nxt_ur)
				tur_q <= 1'b1;
		end
	end

	// Receiver: samples on rising receive clock edges, away from the far end's change
	reg [5:0] rx_div_q;
	reg [3:0] rx_cnt_q;
	reg       rx_hunt_q;
	reg       rx_prev_q;
	reg [7:0] rx_sh_q;
	reg       framed_q;
	reg       seen_q;
	reg [7:0] rx_buf_q;
	reg       rda_q;
	reg       rx_overrun_flag_q;
	reg       rx_end_of_message_flag_q;
	reg       sof_q;
	wire [5:0] rx_fm   = fac_max(mode_q[`MPC_M_FAC_LO +: 2], async);
	wire [5:0] rx_half = rx_fm + {1'b0, rx_fm[5:1]} + {5'h00, rx_fm != 6'h00};
	wire       rx_tick = rx_rise & (rx_div_q == 6'h00) & re_q;
	wire       rx_bit  = nrzi ? (s_rxd == rx_prev_q) : s_rxd;
	wire [7:0] rx_new  = {rx_bit, rx_sh_q[7:1]};
	wire       clr_rx  = rd & (idx == `MPC_IDX_RX_STAT);

	// Character-complete, sync-found and end-of-message decode for this tick
	reg chr_done;
	reg sof_hit;
	reg eom_hit;
	always @*
	begin
		chr_done = 1'b0;
		sof_hit  = 1'b0;
		eom_hit  = 1'b0;
		if (rx_tick)
		begin
			if (async)
				chr_done = ~rx_hunt_q & (rx_cnt_q == 4'h1);
			else if (!framed_q)
				sof_hit = (rx_new == idle_c);
			else if (bit_oriented_protocol_mode & (rx_new == `MPC_FLAG_CHAR))
			begin
				sof_hit = 1'b1;
				eom_hit = seen_q;
			end
			else if (bit_oriented_protocol_mode & (rx_new[7:1] == `MPC_ONES7))
				eom_hit = 1'b1;
			else if (rx_cnt_q == 4'h7)
			begin
				sof_hit  = ~bit_oriented_protocol_mode & (rx_new == synch);
				chr_done = ~sof_hit;
			end
		end
	end

	always @(posedge ref_clk)
	begin
		if (ctl_rst)
		begin
			rx_div_q  <= 6'h00;
			rx_cnt_q  <= 4'h0;
			rx_hunt_q <= 1'b1;
			rx_prev_q <= 1'b1;
			rx_sh_q   <= 8'h00;
			framed_q  <= 1'b0;
			seen_q    <= 1'b0;
			rx_buf_q  <= 8'h00;
			sof_q     <= 1'b0;
		end
		else
		begin
			if (rx_rise & (rx_div_q != 6'h00))
				rx_div_q <= rx_div_q - 6'h01;
			else if (rx_tick & ~(async & rx_hunt_q))
				rx_div_q <= rx_fm;
			if (rx_rise)
				sof_q <= 1'b0;
			if (sof_hit)
				sof_q <= 1'b1;
			if (rx_tick)
			begin
				rx_prev_q <= s_rxd;
				rx_sh_q   <= rx_new;
				if (async)
				begin
					// Start bit found: wait to mid data bit, then 8 data and the stop bit
					if (rx_hunt_q & ~rx_bit)
					begin
						rx_hunt_q <= 1'b0;
						rx_cnt_q  <= 4'h9;
						rx_div_q  <= rx_half;
					end
					else if (!rx_hunt_q)
					begin
						rx_cnt_q <= rx_cnt_q - 4'h1;
						// Stop bit: hunt on every edge again so a start bit right behind is found
						if (rx_cnt_q == 4'h1)
						begin
							rx_hunt_q <= 1'b1;
							rx_div_q  <= 6'h00;
						end
					end
				end
				else
				begin
					rx_cnt_q <= (rx_cnt_q == 4'h7) ? 4'h0 : rx_cnt_q + 4'h1;
					if (sof_hit)
					begin
						framed_q <= 1'b1;
						rx_cnt_q <= 4'h0;
						seen_q   <= 1'b0;
					end
					if (eom_hit & ~sof_hit)
						framed_q <= 1'b0;
					if (chr_done)
						seen_q <= 1'b1;
				end
				if (chr_done)
					rx_buf_q <= async ? rx_sh_q : rx_new;
			end
		end
	end

	// Receive flags: a new event wins over the read that clears it
	always @(posedge ref_clk)
	begin
		if (ctl_rst)
		begin
			rda_q  <= 1'b0;
			rx_overrun_flag_q <= 1'b0;
			rx_end_of_message_flag_q <= 1'b0;
		end
		else
		begin
			if (clr_rx)
			begin
				rda_q  <= 1'b0;
				rx_overrun_flag_q <= 1'b0;
				rx_end_of_message_flag_q <= 1'b0;
			end
			if (chr_done)
				rda_q <= 1'b1;
			if (chr_done & rda_q & ~clr_rx)
				rx_overrun_flag_q <= 1'b1;
			if (eom_hit)
				rx_end_of_message_flag_q <= 1'b1;
		end
	end

	// Register read word; the transmit control word is write-only and reads as zero
	reg  [15:0] rd_w;
	always @*
	begin
		case (idx)
			`MPC_IDX_RX_STAT: rd_w = {rx_overrun_flag_q, rda_q, rx_end_of_message_flag_q, 5'h00, rx_buf_q};
			`MPC_IDX_RX_CTRL: rd_w = {dtr_q, s_misc, 3'h0, re_q, 2'h0,
				tur_q, tbe_q, tor_q, 2'h0, s_cts, s_cd, s_dsr};
			`MPC_IDX_MODE:    rd_w = mode_q;
			default:          rd_w = 16'h0000;
		endcase
	end
	wire [7:0] rd_lane = paddr[`MPC_ADDR_HI_BIT] ? rd_w[15:8] : rd_w[7:0];

	// Read data is taken in the setup cycle so that it stands through the access cycle
	always @(posedge ref_clk)
	begin
		if (reset)
			prdata <= 32'h00000000;
		else if (psel & ~penable)
			prdata <= s_byte ? {24'h000000, rd_lane} : {16'h0000, rd_w};
	end

	// Control register writes; self-clearing start and end of message
	always @(posedge ref_clk)
	begin
		if (ctl_rst)
		begin
			mode_q                <= `MPC_MODE_RST;
			{dtr_q, misc_q, re_q} <= `MPC_RCTL_RST;
			rts_q                 <= 1'b0;
			som_q                 <= 1'b0;
			eom_q                 <= 1'b0;
		end
		else
		begin
			// The bits drop once the transmitter has acted on them; a new write wins
			if (tx_load & nxt_som)
				som_q <= 1'b0;
			if (tx_load & nxt_dat)
				eom_q <= 1'b0;
			if (wr & (idx == `MPC_IDX_MODE) & wr_lo)
				mode_q[7:0] <= pwdata[7:0];
			if (wr & (idx == `MPC_IDX_MODE) & wr_hi)
				mode_q[15:8] <= wd_hi;
			if (wr & (idx == `MPC_IDX_RX_CTRL) & wr_hi)
			begin
				dtr_q  <= wd_hi[`MPC_B_DTR - 8];
				misc_q <= wd_hi[`MPC_B_MISC - 8];
				re_q   <= wd_hi[`MPC_B_RE - 8];
			end
			if (wr_tx & wr_hi)
			begin
				som_q <= wd_hi[`MPC_B_SOM - 8];
				eom_q <= wd_hi[`MPC_B_EOM - 8];
				rts_q <= wd_hi[`MPC_B_RTS - 8];
			end
		end
	end

	// Pins; the general pin is only ever pulled low, with its driver enabled meanwhile
	assign rts_n             = ~rts_q;
	assign dtr_n             = ~dtr_q;
	assign misc_out          = ~misc_q;
	assign misc_oe_n         = ~misc_q;
	assign rx_char_available = rda_q;
	assign tx_buffer_empty   = tbe_q;
	assign rx_sync_flag      = sof_q;
	assign irq_n             = ~(rx_overrun_flag_q | rx_end_of_message_flag_q | tur_q);
endmodule // mpc_serial_ctrl

`default_nettype wire

// File: mpc_serial_ctrl_assertions.sv
// Port-level checks of the serial controller, bound to each controller instance.
// Assumes a 10 ns ref_clk and serial clocks of 80 ns made outside.
`timescale 1ns/1ps
`default_nettype none
module mpc_serial_ctrl_assertions
(
	// Clock, reset and bus
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [7:0] paddr,
	input wire logic       init_n,
	// Serial and status pins
	input wire logic       tx_bit_clock,
	input wire logic       serial_tx_out,
	input wire logic       rts_n,
	input wire logic       dtr_n,
	input wire logic       rx_char_available,
	input wire logic       tx_buffer_empty,
	input wire logic       rx_sync_flag,
	input wire logic       irq_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Finished accesses; a strobe ends at the edge where pready is seen
	wire wr_done = psel && penable && pready && pwrite;
	wire rd_done = psel && penable && pready && !pwrite;
	wire rd_stat = rd_done && paddr[4:2] == 3'h0;
	// Edge detection goes through a synchroniser, so allow one cycle of lag
	property p_tx_edge;
		$changed(serial_tx_out) && init_n |-> tx_bit_clock || $past(tx_bit_clock);
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("tx line moved off a tx clock rise");
	property p_rts_src;
		$changed(rts_n) && init_n |-> $past(wr_done) || $past(wr_done, 2);
	endproperty
	a_rts_src: assert property (p_rts_src) else $error("rts moved without a write");
	property p_dtr_src;
		$changed(dtr_n) && init_n |-> $past(wr_done) || $past(wr_done, 2);
	endproperty
	a_dtr_src: assert property (p_dtr_src) else $error("dtr moved without a write");
	property p_rda_clr;
		$fell(rx_char_available) && init_n |-> $past(rd_stat) || $past(rd_stat, 2);
	endproperty
	a_rda_clr: assert property (p_rda_clr) else $error("char flag fell without a read");
	property p_tx_buffer_empty_edge;
		$fell(tx_buffer_empty) && init_n |-> tx_bit_clock || $past(tx_bit_clock);
	endproperty
	a_tx_buffer_empty_edge: assert property (p_tx_buffer_empty_edge) else $error("empty flag fell off a tx clock rise");
	property p_tx_buffer_empty_clr;
		wr_done && paddr[4:2] == 3'h2 |-> ##[1:24] !tx_buffer_empty;
	endproperty
	a_tx_buffer_empty_clr: assert property (p_tx_buffer_empty_clr) else $error("empty flag stayed after a write");
	property p_sync_len;
		$rose(rx_sync_flag) |-> rx_sync_flag[*8] ##1 !rx_sync_flag;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync pulse not one rx period");
	property p_irq_rel;
		$rose(irq_n) && init_n |-> $past(rd_done) || $past(rd_done, 2);
	endproperty
	a_irq_rel: assert property (p_irq_rel) else $error("irq released without a read");
	property p_init;
		!init_n |-> ##[1:4] rts_n && dtr_n;
	endproperty
	a_init: assert property (p_init) else $error("init left modem outputs driven");
	property p_answer;
		psel && penable |-> ##[0:15] pready;
	endproperty
	a_answer: assert property (p_answer) else $error("bus access not answered");
	property p_slverr;
		psel && penable && paddr[4:2] > 3'h3 |-> pslverr;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");
	// Main scenarios
	c_tx_write: cover property (wr_done && paddr[4:2] == 3'h2);
	c_sync: cover property ($rose(rx_sync_flag));
	c_irq: cover property ($fell(irq_n));
endmodule // mpc_serial_ctrl_assertions

bind mpc_serial_ctrl mpc_serial_ctrl_assertions u_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .init_n(init_n),
	.tx_bit_clock(tx_bit_clock), .serial_tx_out(serial_tx_out), .rts_n(rts_n), .dtr_n(dtr_n),
	.rx_char_available(rx_char_available), .tx_buffer_empty(tx_buffer_empty),
	.rx_sync_flag(rx_sync_flag), .irq_n(irq_n));
`default_nettype wire

// File: mpc_serial_ctrl_regs.vh
// Register indices, field positions, reset values and line codes of the serial controller.
// Definitions only; included by the controller by its bare name.
`ifndef MPC_SERIAL_CTRL_REGS_VH
`define MPC_SERIAL_CTRL_REGS_VH

// Register indices; the byte address on the bus is the index times four
`define MPC_IDX_RX_STAT   3'h0
`define MPC_IDX_RX_CTRL   3'h1
`define MPC_IDX_TX_CTRL   3'h2
`define MPC_IDX_MODE      3'h3
// Address bit that picks the upper byte while the bus runs 8 bits wide
`define MPC_ADDR_HI_BIT   5

// Transmit control and data word
`define MPC_B_SOM         15
`define MPC_B_EOM         12
`define MPC_B_RTS         11
// Receiver control and transmitter status word
`define MPC_B_DTR         15
`define MPC_B_MISC        14
`define MPC_B_RE          10
`define MPC_B_TUR         7
`define MPC_B_TX_BUFFER_EMPTY        6
`define MPC_B_TOR         5
`define MPC_B_CTS         2
`define MPC_B_CD          1
`define MPC_B_DSR         0
// Receive status and data word
`define MPC_B_RX_OVERRUN_FLAG        15
`define MPC_B_RDA         14
`define MPC_B_RX_END_OF_MESSAGE_FLAG        13
// Mode word: protocol [1:0], clock factor [3:2], inverted coding [4], sync char [15:8]
`define MPC_M_PROTO_LO    0
`define MPC_M_FAC_LO      2
`define MPC_M_NRZI        4
`define MPC_M_SYNC_LO     8
`define MPC_PROTO_ASYNC   2'h0
`define MPC_PROTO_BOP     2'h1
`define MPC_PROTO_BCP     2'h2

// Reset values
`define MPC_MODE_RST      16'h1600
`define MPC_RCTL_RST      3'h0

// Clock factor code: edges per bit, minus one (1x, 8x, 16x, 32x)
`define MPC_FAC_1X        6'h00
`define MPC_FAC_8X        6'h07
`define MPC_FAC_16X       6'h0F
`define MPC_FAC_32X       6'h1F

// Line characters
`define MPC_FLAG_CHAR     8'h7E
`define MPC_ABORT_CHAR    8'hFF
`define MPC_ONES7         7'h7F
`define MPC_MARK_WORD     10'h3FF

`endif

// File: mpc_serial_ctrl_tb.sv
// Self-checking bench of the serial controller with an APB master and a far-end model.
// Assumes reads finish when pready is seen; notes are compared by a separate monitor.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_serial_ctrl_regs.vh"
module mpc_serial_ctrl_tb;
	logic ref_clk, reset, psel, penable, pwrite, byte_mode, init_n, cts_n, dsr_n, cd_n, misc_ext, saw_flag;
	logic [7:0] paddr;
	logic [31:0] pwdata, r, exp_q[$], msk_q[$];
	wire [31:0] prdata;
	wire [7:0] got_byte;
	wire pready, pslverr, tx_bit_clock, rx_bit_clock, serial_tx_out, serial_rx_in, rts_n, dtr_n, misc_in;
	wire misc_out, misc_oe_n, rx_char_available, tx_buffer_empty, rx_sync_flag, irq_n, got_t;
	int seed, fail_count, check_count, i, n;
	int reps[4] = '{1, 8, 16, 32};
	// Pin level from the controller's enable and the outside pull
	assign misc_in = misc_oe_n ? misc_ext : misc_out;
	mpc_serial_ctrl dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.byte_mode(byte_mode), .init_n(init_n), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
		.serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in), .rts_n(rts_n), .cts_n(cts_n),
		.dtr_n(dtr_n), .dsr_n(dsr_n), .cd_n(cd_n), .misc_in(misc_in), .misc_out(misc_out),
		.misc_oe_n(misc_oe_n), .rx_char_available(rx_char_available), .tx_buffer_empty(tx_buffer_empty),
		.rx_sync_flag(rx_sync_flag), .irq_n(irq_n));
	mpc_far_end far (.tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .serial_rx_in(serial_rx_in),
		.serial_tx_out(serial_tx_out), .got_byte(got_byte), .got_t(got_t));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function logic [7:0] ad(input logic [2:0] idx);
		ad = {3'h0, idx, 2'h0};
	endfunction
	// Oldest note against what came out
	task cmp(input logic [31:0] v);
		logic [31:0] e;
		logic [31:0] m;
		begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			check_count++;
			if ((v & m) !== (e & m))
			begin
				fail_count++;
				$display("mismatch at %0t: got %h want %h", $time, v, e);
			end
		end
	endtask
	always @(posedge ref_clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp(prdata);
		if (rx_sync_flag === 1'b1)
			saw_flag <= 1'b1;
	end
	always @(got_t)
	begin
		if ($time > 0)
			cmp({24'h0, got_byte});
	end
	// Pin check once outputs have settled; returns on a rising edge
	task chk(input logic ok);
		begin
			repeat (3) @(negedge ref_clk);
			check_count++;
			if (ok !== 1'b1)
			begin
				fail_count++;
				$display("mismatch at %0t: pin level wrong", $time);
			end
			@(posedge ref_clk);
		end
	endtask
	// One APB transfer; an idle cycle after it keeps psel from being set twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk);
			penable <= 1'b1;
			@(posedge ref_clk);
			while (pready !== 1'b1)
				@(posedge ref_clk);
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		begin
			exp_q.push_back(e);
			msk_q.push_back(m);
			apb(1'b0, a, 32'h0);
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, fail_count);
			if (fail_count == 0 && check_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial
	begin
		#500000;
		fail_count++;
		give_verdict;
	end
	initial
	begin
		seed = 17527;
		{reset, psel, penable, pwrite, paddr, pwdata, byte_mode, saw_flag} = {1'b1, 45'h0};
		{init_n, cts_n, dsr_n, cd_n, misc_ext} = 5'h1F;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rd(ad(`MPC_IDX_MODE), 32'h1600, 32'hFFFF);
		byte_mode <= 1'b1;
		// The width pin passes a synchroniser before the read data follows it
		repeat (3) @(posedge ref_clk);
		rd(ad(`MPC_IDX_MODE) | 8'h20, 32'h16, 32'hFF);
		rd(ad(`MPC_IDX_MODE), 32'h00, 32'hFF);
		byte_mode <= 1'b0;
		rd(8'h1C, 32'h0, 32'hFFFFFFFF);
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			{cts_n, dsr_n, cd_n} <= r[2:0];
			repeat (4) @(posedge ref_clk);
			rd(ad(`MPC_IDX_RX_CTRL), {29'h0, ~r[2], ~r[0], ~r[1]}, 32'h7);
		end
		$display("test done: status and width");
		apb(1'b1, ad(`MPC_IDX_MODE), 32'h0);
		apb(1'b1, ad(`MPC_IDX_RX_CTRL), 32'hC400);
		chk(dtr_n === 1'b0 && misc_oe_n === 1'b0 && misc_out === 1'b0);
		rd(ad(`MPC_IDX_RX_CTRL), 32'hC400, 32'hC400);
		init_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		init_n <= 1'b1;
		chk(rts_n === 1'b1 && dtr_n === 1'b1 && misc_oe_n === 1'b1);
		rd(ad(`MPC_IDX_MODE), 32'h1600, 32'hFFFF);
		$display("test done: modem pins and init");
		apb(1'b1, ad(`MPC_IDX_RX_CTRL), 32'h0400);
		for (i = 0; i <= 4; i++)
		begin
			apb(1'b1, ad(`MPC_IDX_MODE), {28'h0, i[1:0] & {2{i < 4}}, 2'h0});
			r = $random(seed);
			far.send_bits({15'h7FFF, r[7:0], 1'b0}, 11, reps[i & 3]);
			if (i == 4)
				far.send_bits({15'h7FFF, ~r[7:0], 1'b0}, 11, 1);
			@(posedge ref_clk);
			for (n = 0; n < 60 && rx_char_available !== 1'b1; n++)
				@(posedge ref_clk);
			chk(rx_char_available === 1'b1 && irq_n === (i < 4));
			rd(ad(`MPC_IDX_RX_STAT), {16'h0, (i == 4), 7'h40, r[7:0]}, i < 4 ? 32'hC0FF : 32'h8000);
			chk(rx_char_available === 1'b0 && irq_n === 1'b1);
		end
		$display("test done: receive");
		cts_n <= 1'b0;
		r = $random(seed);
		exp_q.push_back({24'h0, r[7:0]});
		msk_q.push_back(32'hFF);
		apb(1'b1, ad(`MPC_IDX_TX_CTRL), {20'h0, 4'h8, r[7:0]});
		chk(rts_n === 1'b0);
		@(got_t);
		@(posedge ref_clk);
		$display("test done: transmit");
		apb(1'b1, ad(`MPC_IDX_MODE), 32'h0001);
		far.send_bits(24'h007E7E, 20, 1);
		@(posedge ref_clk);
		chk(saw_flag === 1'b1);
		$display("test done: flag detect");
		give_verdict;
	end
endmodule // mpc_serial_ctrl_tb
`default_nettype wire
